// File: src/per_cfg.svh
`ifndef PER_CFG_SVH
`define PER_CFG_SVH
// How it works
// - writing reset bit 15 starts software reset
// - reset bit reads one until sequence ends
// - finished software reset reloads strap configuration
// - loopback bit 14 routes transmit onto receive
// - self-setting field follows its live event
// - self-clearing field drops once action completes
// - clear-on-read field zeroes after being read, or holds one if an event lands in the read cycle
// - permanent field always reads its fixed value
// - latched-low field holds zero until read
// - latched-high field holds one until read
// - false-carrier counter in low byte, 14h
// - receive-error counter in low byte, 15h
// - coding sublayer controls at 16h
// - carrier-detect test controls at 1Bh

// register indices, byte address is index times four
`define PER_IX_BMC 6'h00
`define PER_IX_RSV_LO 6'h11
`define PER_IX_FCC 6'h14
`define PER_IX_REC 6'h15
`define PER_IX_PCS 6'h16
`define PER_IX_CTL 6'h19
`define PER_IX_TBT 6'h1A
`define PER_IX_CDT 6'h1B
`define PER_IX_LAT 6'h20
`define PER_IX_IST 6'h21
`define PER_IX_IEN 6'h22

// field positions
`define PER_B_RST 15
`define PER_B_LOOP 14
`define PER_B_PASS 10
`define PER_B_GO 9
`define PER_B_PAUSE 7
`define PER_B_POL 4
`define PER_B_LH 0
`define PER_B_LL 1
`define PER_B_SC 2
`define PER_B_P 3
`define PER_I_FC 0
`define PER_I_RX 1
`define PER_I_SR 2

// writable masks and reset values
`define PER_M_PCS 16'h1F27
`define PER_M_CTL 16'h097F
`define PER_M_PA 16'h001F
`define PER_M_TBT 16'h01EB
`define PER_M_CDT 16'hFF1F
`define PER_REG_RST 16'h0000
`define PER_P_VAL 1'b1
`define PER_IRQ_W 3

// counters
`define PER_CNT_W 8
`define PER_CNT_MAX 8'hFF

// soft reset duration
`define PER_CLK_NS 10
`define PER_RST_NS 1000
`define PER_RST_CYC ((`PER_RST_NS + `PER_CLK_NS - 1) / `PER_CLK_NS)
`define PER_RST_W 7

// bus responses
`define PER_RESP_OK 2'h0
`define PER_RESP_ERR 2'h2
`endif

// File: src/per_pkg.sv
package per_pkg;
   typedef enum logic [1:0] {SR_IDLE, SR_BUSY, SR_LOAD} per_sr_t;
   typedef logic [15:0] per_word_t;
endpackage

// File: src/per_ev_if.sv
`timescale 1ns/1ps
`include "per_cfg.svh"
interface per_ev_if;
   logic                   ev;
   logic                   clr;
   logic [`PER_CNT_W-1:0]  cnt;
   modport cnt_side (input ev, input clr, output cnt);
   modport user (output ev, output clr, input cnt);
endinterface

// File: src/per_evcnt.sv
`timescale 1ns/1ps
`include "per_cfg.svh"
module per_evcnt (
   // clock and reset
   input wire logic      ref_clk,
   input wire logic      rst_b,
   // event and count
   per_ev_if.cnt_side    evp
);
   logic [`PER_CNT_W-1:0] cnt_ff;
   logic [`PER_CNT_W-1:0] nxt_cnt;
   wire                   sat = (cnt_ff == `PER_CNT_MAX);

   // event in the read cycle counts after the clear, so none is lost
   assign nxt_cnt = evp.clr ? `PER_CNT_W'(evp.ev) :
                    (evp.ev && !sat) ? cnt_ff + 1'b1 : cnt_ff;
   assign evp.cnt = cnt_ff;

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_ff <= '0;
      else
         cnt_ff <= nxt_cnt;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_cor_clear:
      assert property (evp.clr && !evp.ev |=> cnt_ff == '0)
         else $error("counter not cleared by read");
   a_cnt_step:
      assert property (!evp.clr && evp.ev && !sat |=> cnt_ff == $past(cnt_ff) + 1'b1)
         else $error("counter missed an event");
endmodule

// File: src/per_latch.sv
`timescale 1ns/1ps
module per_latch #(
   parameter bit LOW = 1'b0
) (
   // clock and reset
   input wire logic  ref_clk,
   input wire logic  rst_b,
   // event and read strobe
   input wire logic  ev,
   input wire logic  rd,
   // field value
   output logic      value
);
   logic caught_ff;
   logic nxt_caught;

   // set wins over the clearing read
   assign nxt_caught = ev | (caught_ff & ~rd);
   assign value      = LOW ? ~caught_ff : caught_ff;

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         caught_ff <= 1'b0;
      else
         caught_ff <= nxt_caught;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_latch_hold:
      assert property (caught_ff && !rd |=> caught_ff)
         else $error("latched field released without read");
   a_latch_set:
      assert property (ev |=> value == !LOW)
         else $error("latched field missed its event");
endmodule

// File: src/per_regbank.sv
`timescale 1ns/1ps
`include "per_cfg.svh"
module per_regbank (
   // clock and reset
   input wire logic         ref_clk,
   input wire logic         rst_b,
   // axi4-lite write
   input wire logic [7:0]   s_axi_awaddr,
   input wire logic         s_axi_awvalid,
   output logic             s_axi_awready,
   input wire logic [31:0]  s_axi_wdata,
   input wire logic [3:0]   s_axi_wstrb,
   input wire logic         s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input wire logic         s_axi_bready,
   // axi4-lite read
   input wire logic [7:0]   s_axi_araddr,
   input wire logic         s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input wire logic         s_axi_rready,
   // mii data paths
   input wire logic [3:0]   mii_txd,
   input wire logic         mii_tx_en,
   input wire logic [3:0]   line_rxd,
   input wire logic         line_rx_dv,
   output logic [3:0]       mii_rxd,
   output logic             mii_rx_dv,
   // line events and status
   input wire logic         false_carrier_ev,
   input wire logic         rx_error_ev,
   input wire logic         link_ok,
   input wire logic         carrier_active,
   input wire logic         self_test_done,
   input wire logic         self_test_result,
   input wire logic         flow_pause_state,
   input wire logic         polarity_state,
   // straps
   input wire logic [4:0]   strap_port_address,
   // configuration outputs
   output logic             loopback,
   output logic             soft_reset_busy,
   output logic             self_test_go,
   output logic [15:0]      pcs_cfg,
   output logic [15:0]      ctl_cfg,
   output logic [15:0]      tbt_cfg,
   output logic [15:0]      cdt_cfg,
   // interrupt
   output logic             irq
);
   per_pkg::per_sr_t        sr_st_ff;
   per_pkg::per_sr_t        nxt_sr_st;
   logic [`PER_RST_W-1:0]   sr_cnt_ff;
   logic [`PER_RST_W-1:0]   nxt_sr_cnt;
   logic                    strap_ld_ff;
   logic                    loop_ff;
   logic                    nxt_loop;
   logic                    go_ff;
   logic                    nxt_go;
   per_pkg::per_word_t      pcs_ff;
   per_pkg::per_word_t      nxt_pcs;
   per_pkg::per_word_t      ctl_ff;
   per_pkg::per_word_t      nxt_ctl;
   per_pkg::per_word_t      tbt_ff;
   per_pkg::per_word_t      nxt_tbt;
   per_pkg::per_word_t      cdt_ff;
   per_pkg::per_word_t      nxt_cdt;
   logic [`PER_IRQ_W-1:0]   ist_ff;
   logic [`PER_IRQ_W-1:0]   nxt_ist;
   logic [`PER_IRQ_W-1:0]   ien_ff;
   logic [`PER_IRQ_W-1:0]   nxt_ien;
   logic                    bvalid_ff;
   logic [1:0]              bresp_ff;
   logic                    rvalid_ff;
   logic [1:0]              rresp_ff;
   logic [31:0]             rdata_ff;
   logic [3:0]              rxd_ff;
   logic                    rxdv_ff;
   per_pkg::per_word_t      bmc_v;
   per_pkg::per_word_t      ctl_v;
   per_pkg::per_word_t      tbt_v;
   per_pkg::per_word_t      lat_v;
   per_pkg::per_word_t      rd_val;
   logic                    lh_v;
   logic                    ll_v;

   function automatic per_pkg::per_word_t mrg(input per_pkg::per_word_t cur,
                                              input logic [31:0] d,
                                              input logic [3:0] be);
      mrg = {be[1] ? d[15:8] : cur[15:8], be[0] ? d[7:0] : cur[7:0]};
   endfunction

   function automatic logic mapped(input logic [5:0] ix);
      mapped = (ix == `PER_IX_BMC) || (ix >= `PER_IX_RSV_LO && ix <= `PER_IX_IEN);
   endfunction

   // write decode; both channels taken together, writes dropped while resetting
   wire        wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
   wire [5:0]  wix   = s_axi_awaddr[7:2];
   wire        idle  = (sr_st_ff == per_pkg::SR_IDLE);
   wire        wr_ok = wr_go & idle;
   wire        w_bmc = wr_ok & (wix == `PER_IX_BMC);
   wire        w_pcs = wr_ok & (wix == `PER_IX_PCS);
   wire        w_ctl = wr_ok & (wix == `PER_IX_CTL);
   wire        w_tbt = wr_ok & (wix == `PER_IX_TBT);
   wire        w_cdt = wr_ok & (wix == `PER_IX_CDT);
   wire        w_ist = wr_ok & (wix == `PER_IX_IST);
   wire        w_ien = wr_ok & (wix == `PER_IX_IEN);
   wire [15:0] wd_bmc = mrg(bmc_v, s_axi_wdata, s_axi_wstrb);
   wire [15:0] wd_ctl = mrg(ctl_ff, s_axi_wdata, s_axi_wstrb);
   wire [15:0] wd_ist = mrg(16'(ist_ff), s_axi_wdata, s_axi_wstrb);
   wire [15:0] wd_ien = mrg(16'(ien_ff), s_axi_wdata, s_axi_wstrb);

   // read decode; read side effects fire on the address handshake
   wire        rd_go  = s_axi_arvalid & ~rvalid_ff;
   wire [5:0]  rix    = s_axi_araddr[7:2];
   wire        rd_fcc = rd_go & (rix == `PER_IX_FCC);
   wire        rd_rec = rd_go & (rix == `PER_IX_REC);
   wire        rd_lat = rd_go & (rix == `PER_IX_LAT);

   // soft reset sequencer
   wire sr_start = w_bmc & wd_bmc[`PER_B_RST];
   wire sr_last  = (sr_cnt_ff == `PER_RST_W'(`PER_RST_CYC - 1));
   wire restrap  = strap_ld_ff | (sr_st_ff == per_pkg::SR_LOAD);

   always_comb
   begin
      nxt_sr_st  = sr_st_ff;
      nxt_sr_cnt = sr_cnt_ff;
      case (sr_st_ff)
         per_pkg::SR_IDLE:
         begin
            nxt_sr_cnt = '0;
            if (sr_start)
               nxt_sr_st = per_pkg::SR_BUSY;
         end
         per_pkg::SR_BUSY:
         begin
            nxt_sr_cnt = sr_cnt_ff + 1'b1;
            if (sr_last)
               nxt_sr_st = per_pkg::SR_LOAD;
         end
         per_pkg::SR_LOAD:
            nxt_sr_st = per_pkg::SR_IDLE;
         default:
            nxt_sr_st = per_pkg::SR_IDLE;
      endcase
   end

   // register next values; restrap puts every control except the interrupt enables back to its default
   assign nxt_loop = restrap ? 1'b0 : w_bmc ? wd_bmc[`PER_B_LOOP] : loop_ff;
   assign nxt_pcs  = restrap ? `PER_REG_RST :
                     w_pcs ? mrg(pcs_ff, s_axi_wdata, s_axi_wstrb) & `PER_M_PCS : pcs_ff;
   assign nxt_ctl  = restrap ? ((`PER_REG_RST & ~`PER_M_PA) | 16'(strap_port_address)) :
                     w_ctl ? wd_ctl & `PER_M_CTL : ctl_ff;
   assign nxt_tbt  = restrap ? `PER_REG_RST :
                     w_tbt ? mrg(tbt_ff, s_axi_wdata, s_axi_wstrb) & `PER_M_TBT : tbt_ff;
   assign nxt_cdt  = restrap ? `PER_REG_RST :
                     w_cdt ? mrg(cdt_ff, s_axi_wdata, s_axi_wstrb) & `PER_M_CDT : cdt_ff;
   // a write of one beats a completion in the same cycle
   assign nxt_go   = restrap ? 1'b0 : (w_ctl & wd_ctl[`PER_B_GO]) ? 1'b1 :
                     self_test_done ? 1'b0 : go_ff;

   // interrupt status, set wins over write-one-to-clear
   wire [`PER_IRQ_W-1:0] ev_vec = {sr_st_ff == per_pkg::SR_LOAD, rx_error_ev, false_carrier_ev};
   assign nxt_ist = (ist_ff & ~(w_ist ? wd_ist[`PER_IRQ_W-1:0] : '0)) | ev_vec;
   assign nxt_ien = w_ien ? wd_ien[`PER_IRQ_W-1:0] : ien_ff;
   assign irq     = |(ist_ff & ien_ff);

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sr_st_ff    <= per_pkg::SR_IDLE;
         sr_cnt_ff   <= '0;
         strap_ld_ff <= 1'b1;
         loop_ff     <= 1'b0;
         go_ff       <= 1'b0;
         pcs_ff      <= `PER_REG_RST;
         ctl_ff      <= `PER_REG_RST;
         tbt_ff      <= `PER_REG_RST;
         cdt_ff      <= `PER_REG_RST;
         ist_ff      <= '0;
         ien_ff      <= '0;
      end
      else
      begin
         sr_st_ff    <= nxt_sr_st;
         sr_cnt_ff   <= nxt_sr_cnt;
         strap_ld_ff <= 1'b0;
         loop_ff     <= nxt_loop;
         go_ff       <= nxt_go;
         pcs_ff      <= nxt_pcs;
         ctl_ff      <= nxt_ctl;
         tbt_ff      <= nxt_tbt;
         cdt_ff      <= nxt_cdt;
         ist_ff      <= nxt_ist;
         ien_ff      <= nxt_ien;
      end
   end

   // event counters, cleared by read and by restrap
   per_ev_if fc_if ();
   per_ev_if re_if ();
   assign fc_if.ev  = false_carrier_ev;
   assign fc_if.clr = rd_fcc | restrap;
   assign re_if.ev  = rx_error_ev;
   assign re_if.clr = rd_rec | restrap;

   per_evcnt u_fcc (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .evp     (fc_if)
   );

   per_evcnt u_rec (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .evp     (re_if)
   );

   // latched receive error and latched-low link
   per_latch #(.LOW(1'b0)) u_lh (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .ev      (rx_error_ev),
      .rd      (rd_lat | restrap),
      .value   (lh_v)
   );

   per_latch #(.LOW(1'b1)) u_ll (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .ev      (~link_ok),
      .rd      (rd_lat | restrap),
      .value   (ll_v)
   );

   // read views with live and fixed fields inserted
   always_comb
   begin
      bmc_v                = '0;
      bmc_v[`PER_B_RST]    = ~idle;
      bmc_v[`PER_B_LOOP]   = loop_ff;
      ctl_v                = ctl_ff;
      ctl_v[`PER_B_GO]     = go_ff;
      ctl_v[`PER_B_PASS]   = self_test_result;
      ctl_v[`PER_B_PAUSE]  = flow_pause_state;
      tbt_v                = tbt_ff;
      tbt_v[`PER_B_POL]    = polarity_state;
      lat_v                = '0;
      lat_v[`PER_B_LH]     = lh_v;
      lat_v[`PER_B_LL]     = ll_v;
      lat_v[`PER_B_SC]     = carrier_active;
      lat_v[`PER_B_P]      = `PER_P_VAL;
   end

   always_comb
   begin
      case (rix)
         `PER_IX_BMC: rd_val = bmc_v;
         `PER_IX_FCC: rd_val = 16'(fc_if.cnt);
         `PER_IX_REC: rd_val = 16'(re_if.cnt);
         `PER_IX_PCS: rd_val = pcs_ff;
         `PER_IX_CTL: rd_val = ctl_v;
         `PER_IX_TBT: rd_val = tbt_v;
         `PER_IX_CDT: rd_val = cdt_ff;
         `PER_IX_LAT: rd_val = lat_v;
         `PER_IX_IST: rd_val = 16'(ist_ff);
         `PER_IX_IEN: rd_val = 16'(ien_ff);
         default:     rd_val = '0;
      endcase
   end

   // bus answers and loopback path, all registered
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= `PER_RESP_OK;
         rvalid_ff <= 1'b0;
         rresp_ff  <= `PER_RESP_OK;
         rdata_ff  <= '0;
         rxd_ff    <= '0;
         rxdv_ff   <= 1'b0;
      end
      else
      begin
         if (wr_go)
         begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= mapped(wix) ? `PER_RESP_OK : `PER_RESP_ERR;
         end
         else if (s_axi_bready)
            bvalid_ff <= 1'b0;
         if (rd_go)
         begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= mapped(rix) ? `PER_RESP_OK : `PER_RESP_ERR;
            rdata_ff  <= 32'(rd_val);
         end
         else if (s_axi_rready)
            rvalid_ff <= 1'b0;
         rxd_ff  <= loop_ff ? mii_txd : line_rxd;
         rxdv_ff <= loop_ff ? mii_tx_en : line_rx_dv;
      end
   end

   assign s_axi_awready   = wr_go;
   assign s_axi_wready    = wr_go;
   assign s_axi_bvalid    = bvalid_ff;
   assign s_axi_bresp     = bresp_ff;
   assign s_axi_arready   = rd_go;
   assign s_axi_rvalid    = rvalid_ff;
   assign s_axi_rresp     = rresp_ff;
   assign s_axi_rdata     = rdata_ff;
   assign mii_rxd         = rxd_ff;
   assign mii_rx_dv       = rxdv_ff;
   assign loopback        = loop_ff;
   assign soft_reset_busy = ~idle;
   assign self_test_go    = go_ff;
   assign pcs_cfg         = pcs_ff;
   assign ctl_cfg         = ctl_v;
   assign tbt_cfg         = tbt_ff;
   assign cdt_cfg         = cdt_ff;

   localparam int RST_MAX = `PER_RST_CYC + 2;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_rst_start:
      assert property (sr_start |=> sr_st_ff == per_pkg::SR_BUSY)
         else $error("soft reset did not start");
   a_rst_ends:
      assert property ($rose(sr_st_ff == per_pkg::SR_BUSY) |-> ##[1:RST_MAX] idle)
         else $error("soft reset did not self clear");
   a_rst_reads:
      assert property (rd_go && rix == `PER_IX_BMC && !idle |=> s_axi_rdata[`PER_B_RST])
         else $error("reset bit read zero while busy");
   a_strap_load:
      assert property (sr_st_ff == per_pkg::SR_LOAD
                       |=> (ctl_ff & `PER_M_PA) == 16'($past(strap_port_address)))
         else $error("straps not reloaded");
   a_loop_route:
      assert property (loop_ff |=> mii_rxd == $past(mii_txd) && mii_rx_dv == $past(mii_tx_en))
         else $error("loopback path wrong");
   a_sc_live:
      assert property (rd_lat |=> s_axi_rdata[`PER_B_SC] == $past(carrier_active))
         else $error("self-setting field not live");
   a_go_clear:
      assert property (go_ff && self_test_done && !w_ctl |=> !go_ff)
         else $error("self-clearing field stuck");
   a_fixed_one:
      assert property (rd_lat |=> s_axi_rdata[`PER_B_P] == `PER_P_VAL)
         else $error("permanent field changed");
   a_fcc_read:
      assert property (rd_fcc |=> s_axi_rdata == 32'($past(fc_if.cnt)))
         else $error("false carrier read wrong");
   a_rec_read:
      assert property (rd_rec |=> s_axi_rdata == 32'($past(re_if.cnt)))
         else $error("receive error read wrong");
   a_pcs_mask:
      assert property (w_pcs |=> (pcs_ff & ~`PER_M_PCS) == '0)
         else $error("pcs reserved bit stored");
   a_cdt_mask:
      assert property (w_cdt |=> (cdt_ff & ~`PER_M_CDT) == '0)
         else $error("cd test reserved bit stored");
   a_resv_zero:
      assert property (rd_go && rix > `PER_IX_CDT && rix < `PER_IX_LAT |=> s_axi_rdata == '0)
         else $error("reserved offset read nonzero");
   a_irq_raise:
      assert property (false_carrier_ev && ien_ff[`PER_I_FC] && !w_ien |=> irq)
         else $error("interrupt not raised");

   c_soft_reset:
      cover property (sr_st_ff == per_pkg::SR_LOAD);
   c_loopback:
      cover property (loop_ff && mii_tx_en);
   c_read_event:
      cover property (rd_fcc && false_carrier_ev);
   c_irq:
      cover property (irq && w_ist);
endmodule

// File: tb/per_mgmt_model.sv
`timescale 1ns/1ps
module per_mgmt_model (
   // clock
   input wire logic         ref_clk,
   // write channels
   output logic [7:0]       awaddr,
   output logic             awvalid,
   input wire logic         awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input wire logic         wready,
   input wire logic [1:0]   bresp,
   input wire logic         bvalid,
   output logic             bready,
   // read channels
   output logic [7:0]       araddr,
   output logic             arvalid,
   input wire logic         arready,
   input wire logic [31:0]  rdata,
   input wire logic [1:0]   rresp,
   input wire logic         rvalid,
   output logic             rready,
   // a wait ran out
   output logic             hung
);
   // answer channels always ready, so no release races between calls
   initial {awaddr, wdata, wstrb, araddr, awvalid, wvalid, arvalid, hung} = '0;
   initial {bready, rready} = 2'b11;

   // call right after a rising edge
   task automatic wr(input logic [5:0] ix, input logic [15:0] d, output logic [1:0] rsp);
      int n;
      begin
         n = 0;
         awaddr <= {ix, 2'b00};
         wdata <= {16'h0000, d};
         wstrb <= 4'h3;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         @(negedge ref_clk);
         while (!(awready && wready) && n < 100)
         begin
            @(negedge ref_clk);
            n++;
         end
         @(posedge ref_clk);
         awvalid <= 1'b0;
         wvalid <= 1'b0;
         // released lines show garbage, not the old value
         awaddr <= ~awaddr;
         wdata <= ~wdata;
         @(negedge ref_clk);
         while (!bvalid && n < 100)
         begin
            @(negedge ref_clk);
            n++;
         end
         rsp = bresp;
         @(posedge ref_clk);
         if (n >= 100) hung <= 1'b1;
      end
   endtask

   task automatic rd(input logic [5:0] ix, output logic [31:0] d, output logic [1:0] rsp);
      int n;
      begin
         n = 0;
         araddr <= {ix, 2'b00};
         arvalid <= 1'b1;
         @(negedge ref_clk);
         while (!arready && n < 100)
         begin
            @(negedge ref_clk);
            n++;
         end
         @(posedge ref_clk);
         arvalid <= 1'b0;
         araddr <= ~araddr;
         @(negedge ref_clk);
         while (!rvalid && n < 100)
         begin
            @(negedge ref_clk);
            n++;
         end
         d = rdata;
         rsp = rresp;
         @(posedge ref_clk);
         if (n >= 100) hung <= 1'b1;
      end
   endtask
endmodule

// File: tb/phy_extended_register_bank_bench.sv
`timescale 1ns/1ps
`include "per_cfg.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
   $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module phy_extended_register_bank_bench;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, hung;
   logic [31:0] wdata, rdata, rv;
   logic [3:0]  wstrb, rxd;
   logic [1:0]  bresp, rresp, rsp;
   logic [3:0]  txd = 4'h0, lrxd = 4'h0;
   logic        tx_en = 0, lrx_dv = 0, fc_ev = 0, rx_ev = 0, link = 1, carr = 0;
   logic        st_done = 0, st_res = 0, pause = 0, pol = 0;
   logic        rx_dv, loopback, busy, st_go, irq;
   logic [4:0]  strap = 5'h00;
   logic [15:0] pcs, ctl, tbt, cdt, v;
   logic [5:0]  wix [3] = '{`PER_IX_PCS, `PER_IX_TBT, `PER_IX_CDT};
   logic [15:0] wmk [3] = '{`PER_M_PCS, `PER_M_TBT, `PER_M_CDT};
   int          fail_count = 0, tests_run = 0, n, i, j;

   always #5 ref_clk = ~ref_clk;

   per_regbank dut (.ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .mii_txd(txd), .mii_tx_en(tx_en), .line_rxd(lrxd),
      .line_rx_dv(lrx_dv), .mii_rxd(rxd), .mii_rx_dv(rx_dv), .false_carrier_ev(fc_ev),
      .rx_error_ev(rx_ev), .link_ok(link), .carrier_active(carr),
      .self_test_done(st_done), .self_test_result(st_res), .flow_pause_state(pause),
      .polarity_state(pol), .strap_port_address(strap), .loopback(loopback),
      .soft_reset_busy(busy), .self_test_go(st_go), .pcs_cfg(pcs), .ctl_cfg(ctl),
      .tbt_cfg(tbt), .cdt_cfg(cdt), .irq(irq));

   per_mgmt_model mdl (.ref_clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .hung(hung));

   function logic [15:0] sat(input int k);
      return (k > 255) ? 16'h00FF : 16'(k);
   endfunction

   function logic [4:0] exp_rx(input logic lb);
      return lb ? {tx_en, txd} : {lrx_dv, lrxd};
   endfunction

   task chk_rd(input logic [5:0] ix, input logic [15:0] e);
      mdl.rd(ix, rv, rsp);
      `CHK(rv, {16'h0000, e})
      `CHK(rsp, `PER_RESP_OK)
   endtask

   task wr(input logic [5:0] ix, input logic [15:0] d);
      mdl.wr(ix, d, rsp);
      `CHK(rsp, `PER_RESP_OK)
   endtask

   task tally_and_finish();
      if (fail_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // a stuck handshake ends the run
   always @(posedge hung)
   begin
      fail_count++;
      tally_and_finish();
   end

   initial
   begin
      void'($urandom(32'h44ED460D));
      strap <= 5'($urandom);
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk_rd(`PER_IX_PCS, `PER_REG_RST);
      chk_rd(`PER_IX_CTL, {11'h000, strap});
      for (i = 0; i < 3; i++)
      begin
         v = 16'($urandom);
         wr(wix[i], v);
         chk_rd(wix[i], v & wmk[i]);
         `CHK(i == 0 ? pcs : (i == 1 ? tbt : cdt), v & wmk[i])
      end
      wr(6'h17, 16'hFFFF);
      chk_rd(6'h17, 16'h0000);
      chk_rd(`PER_IX_RSV_LO, 16'h0000);
      chk_rd(6'h1F, 16'h0000);
      mdl.rd(6'h01, rv, rsp);
      `CHK(rsp, `PER_RESP_ERR)
      // random burst, then one long enough to saturate
      for (j = 0; j < 2; j++)
      begin
         n = j ? 300 : 1 + $urandom % 20;
         fc_ev <= 1'b1;
         rx_ev <= 1'b1;
         repeat (n) @(posedge ref_clk);
         fc_ev <= 1'b0;
         rx_ev <= 1'b0;
         @(posedge ref_clk);
         chk_rd(`PER_IX_FCC, sat(n));
         chk_rd(`PER_IX_FCC, 16'h0000);
         chk_rd(`PER_IX_REC, sat(n));
         chk_rd(`PER_IX_REC, 16'h0000);
      end
      link <= 1'b0;
      @(posedge ref_clk);
      link <= 1'b1;
      @(posedge ref_clk);
      chk_rd(`PER_IX_LAT, 16'h0009);
      carr <= 1'b1;
      wr(`PER_IX_LAT, 16'h0000);
      chk_rd(`PER_IX_LAT, 16'h000E);
      carr <= 1'b0;
      @(posedge ref_clk);
      chk_rd(`PER_IX_LAT, 16'h000A);
      chk_rd(`PER_IX_IST, 16'h0003);
      `CHK(irq, 1'b0)
      // false carrier status is still set from the bursts, so unmasking it raises the line at once
      wr(`PER_IX_IEN, 16'h0001);
      fc_ev <= 1'b1;
      @(posedge ref_clk);
      fc_ev <= 1'b0;
      @(posedge ref_clk);
      `CHK(irq, 1'b1)
      wr(`PER_IX_IEN, 16'h0002);
      `CHK(irq, 1'b1)
      wr(`PER_IX_IST, 16'h0002);
      `CHK(irq, 1'b0)
      chk_rd(`PER_IX_IST, 16'h0001);
      wr(`PER_IX_IST, 16'h0001);
      for (j = 1; j >= 0; j--)
      begin
         wr(`PER_IX_BMC, j ? 16'h4000 : 16'h0000);
         `CHK(loopback, j[0])
         for (i = 0; i < 4; i++)
         begin
            {tx_en, txd, lrx_dv, lrxd} <= 10'($urandom);
            @(posedge ref_clk);
            @(negedge ref_clk);
            `CHK({rx_dv, rxd}, exp_rx(j[0]))
            @(posedge ref_clk);
         end
      end
      st_res <= 1'b1;
      pause <= 1'b1;
      wr(`PER_IX_CTL, 16'h0200);
      chk_rd(`PER_IX_CTL, 16'h0680);
      `CHK(st_go, 1'b1)
      `CHK(ctl, 16'h0680)
      st_done <= 1'b1;
      @(posedge ref_clk);
      st_done <= 1'b0;
      chk_rd(`PER_IX_CTL, 16'h0480);
      // soft reset must bring config and strap back
      wr(`PER_IX_PCS, 16'h1F27);
      strap <= ~strap;
      wr(`PER_IX_BMC, 16'h8000);
      chk_rd(`PER_IX_BMC, 16'h8000);
      `CHK(busy, 1'b1)
      n = 0;
      while (busy && n < 300)
      begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 300)
      begin
         fail_count++;
         tally_and_finish();
      end
      chk_rd(`PER_IX_BMC, 16'h0000);
      chk_rd(`PER_IX_PCS, 16'h0000);
      chk_rd(`PER_IX_CTL, {11'h024, strap});
      `CHK(ctl, {11'h024, strap})
      `CHK(pcs, 16'h0000)
      chk_rd(`PER_IX_IST, 16'h0004);
      wr(`PER_IX_IEN, 16'h0004);
      `CHK(irq, 1'b1)
      wr(`PER_IX_IST, 16'h0004);
      `CHK(irq, 1'b0)
      tally_and_finish();
   end
endmodule
